// *** sfb_pkg.sv ***
// Package of offsets, bit positions, reset values and types for the SFR bank
package sfb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    // Register indexes; the byte address is four times the index
    localparam int IDX_LSB = 2;
    localparam logic [ADDR_W-1:0] ADDR_SYS_FLAGS = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_SER_FLAGS = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_ENABLES_ONE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SER_ENABLES = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 8'h10;
    // System flag positions
    localparam int BIT_WDOG = 0;
    localparam int BIT_OSC = 1;
    localparam int BIT_NMI = 4;
    // Serial flag and enable positions
    localparam int BIT_RX = 0;
    localparam int BIT_TX = 1;
    // Enable register positions
    localparam int BIT_IE_WDOG = 0;
    localparam int BIT_IE_OSC = 1;
    localparam int BIT_IE_NMI = 4;
    localparam int BIT_IE_RX = 5;
    localparam int BIT_IE_TX = 6;
    localparam int NUM_EVT = 5;
    localparam logic [REG_W-1:0] SYS_MASK = 8'h13;
    localparam logic [REG_W-1:0] SER_MASK = 8'h03;
    localparam logic [REG_W-1:0] IE_MASK = 8'h73;
    localparam logic [REG_W-1:0] PUC_VALUE = 8'h00;
    localparam logic [REG_W-1:0] POR_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic watchdog_overflow;
        logic key_violation;
        logic osc_fault;
        logic pin_nmi;
        logic serial_rx;
        logic serial_tx;
    } sfb_events_t;

    typedef struct packed {
        logic watchdog_int;
        logic osc_int;
        logic nmi_int;
        logic rx_int;
        logic tx_int;
    } sfb_requests_t;

    typedef enum logic [1:0] {
        SFB_IDLE,
        SFB_ACCESS
    } sfb_bus_state_t;
endpackage

// *** sfb_flag_cell.sv ***
// One sticky flag bit: set by event or write, cleared by write or reset
module sfb_flag_cell (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear_sync,
    input wire logic hw_set,
    input wire logic wr_en,
    input wire logic wr_val,
    output logic flag
);
    logic next_flag;

    always_comb begin
        next_flag = flag;
        if (wr_en) begin
            next_flag = wr_val;
        end
        if (hw_set) begin
            next_flag = 1'b1;
        end
        if (clear_sync) begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule // sfb_flag_cell

// *** sfb_bank.sv ***
// Special-function flag and module enable register bank on APB
// What this block does
// - The watchdog flag sets on watchdog-mode overflow or key violation.
// - The watchdog flag clears on power-on, on a pin reset in reset mode, or on a write of 0 to bit 0 of 02h.
// - The oscillator fault flag sets whenever a fault is detected and power-up clear is low.
// - The pin NMI flag sets on any NMI event from the pin, with no mode gating.
// - Register 03h bit 0 is the read/write serial receive flag, cleared by POWER_UP_CLEAR.
// - Register 03h bit 1 is the read/write serial transmit flag, cleared by POWER_UP_CLEAR.
// - Register 05h holds async receive enable bit 0, transmit enable bit 1.
// - In synchronous mode bit 0 of 05h enables both transmit and receive.
// - Power-up-clear bits take their reset value on every power-up clear.
// - Power-on bits take their reset value only on power-on reset.
// - Unassigned bits, all of 04h and bits 7..2 of 03h/05h, are absent.
// - Oscillator and NMI requests obey their enable but not global enable.
// - Watchdog enable gates only in interval mode, not in watchdog mode.
module sfb_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic power_up_clear,
    input wire logic pin_reset_mode_reset,
    input wire logic watchdog_mode,
    input wire logic sync_mode,
    input wire sfb_pkg::sfb_events_t events,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sfb_pkg::ADDR_W-1:0] paddr,
    input wire logic [sfb_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [sfb_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output sfb_pkg::sfb_requests_t requests,
    output logic async_rx_enable,
    output logic async_tx_enable,
    output logic sync_serial_enable,
    output logic irq
);
    localparam int RW = sfb_pkg::REG_W;

    logic access;
    logic wr;
    logic lane0;
    logic wr_sys;
    logic wr_ser;
    logic wr_en_reg;
    logic wr_ie;
    logic wr_stat;
    logic wr_mask;
    logic mapped;
    logic [RW-1:0] wdata;
    logic watchdog_event_flag;
    logic osc_fault_flag;
    logic pin_nmi_flag;
    logic serial_rx_flag;
    logic serial_tx_flag;
    logic [RW-1:0] serial_enables;
    logic [RW-1:0] next_serial_enables;
    logic [RW-1:0] int_enable;
    logic [RW-1:0] next_int_enable;
    logic [sfb_pkg::NUM_EVT-1:0] evt_status;
    logic [sfb_pkg::NUM_EVT-1:0] next_evt_status;
    logic [sfb_pkg::NUM_EVT-1:0] evt_mask;
    logic [sfb_pkg::NUM_EVT-1:0] next_evt_mask;
    logic [sfb_pkg::NUM_EVT-1:0] evt_pulse;
    logic [RW-1:0] sys_view;
    logic [RW-1:0] ser_view;
    logic [sfb_pkg::DATA_W-1:0] rdata_mux;
    logic [sfb_pkg::DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    sfb_pkg::sfb_requests_t next_requests;
    logic next_irq;
    logic next_rx_en;
    logic next_tx_en;
    logic next_sync_en;
    logic wdog_clear;
    logic wdog_set;
    logic [sfb_pkg::ADDR_W-1:0] reg_index;
    logic aligned;
    logic wr_ok;
    sfb_pkg::sfb_bus_state_t state;
    sfb_pkg::sfb_bus_state_t next_state;

    // One register per word; the index drops the byte offset
    assign reg_index = {{sfb_pkg::IDX_LSB{1'b0}},
        paddr[sfb_pkg::ADDR_W-1:sfb_pkg::IDX_LSB]};
    assign aligned = (paddr[sfb_pkg::IDX_LSB-1:0] == '0);

    // Bus decode; write takes effect at the access edge
    assign access = psel && penable && (state == sfb_pkg::SFB_ACCESS);
    assign wr = access && pwrite;
    assign lane0 = pstrb[0];
    // Misaligned writes must not alias onto a register
    assign wr_ok = wr && lane0 && aligned;
    assign wdata = pwdata[RW-1:0];
    assign wr_sys = wr_ok && (reg_index == sfb_pkg::ADDR_SYS_FLAGS);
    assign wr_ser = wr_ok && (reg_index == sfb_pkg::ADDR_SER_FLAGS);
    assign wr_en_reg = wr_ok && (reg_index == sfb_pkg::ADDR_SER_ENABLES);
    assign wr_ie = wr_ok && (reg_index == sfb_pkg::ADDR_INT_ENABLE);
    assign wr_stat = wr_ok && (reg_index == sfb_pkg::ADDR_EVT_STATUS);
    assign wr_mask = wr_ok && (reg_index == sfb_pkg::ADDR_EVT_MASK);
    assign wdog_clear = pin_reset_mode_reset;
    assign wdog_set = (events.watchdog_overflow && watchdog_mode)
        || events.key_violation;

    // Watchdog flag keeps its value across power-up clear
    sfb_flag_cell u_wdog (
        .pclk(pclk),
        .presetn(presetn),
        .clear_sync(wdog_clear),
        .hw_set(wdog_set),
        .wr_en(wr_sys),
        .wr_val(wdata[sfb_pkg::BIT_WDOG]),
        .flag(watchdog_event_flag)
    );

    // Power-up-clear flags; the clear wins over a same-cycle event
    sfb_flag_cell u_osc (
        .pclk(pclk),
        .presetn(presetn),
        .clear_sync(power_up_clear),
        .hw_set(events.osc_fault),
        .wr_en(wr_sys),
        .wr_val(wdata[sfb_pkg::BIT_OSC]),
        .flag(osc_fault_flag)
    );
    sfb_flag_cell u_nmi (
        .pclk(pclk),
        .presetn(presetn),
        .clear_sync(power_up_clear),
        .hw_set(events.pin_nmi),
        .wr_en(wr_sys),
        .wr_val(wdata[sfb_pkg::BIT_NMI]),
        .flag(pin_nmi_flag)
    );

    // Serial port flags, also cleared by power-up clear
    sfb_flag_cell u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .clear_sync(power_up_clear),
        .hw_set(events.serial_rx),
        .wr_en(wr_ser),
        .wr_val(wdata[sfb_pkg::BIT_RX]),
        .flag(serial_rx_flag)
    );
    sfb_flag_cell u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .clear_sync(power_up_clear),
        .hw_set(events.serial_tx),
        .wr_en(wr_ser),
        .wr_val(wdata[sfb_pkg::BIT_TX]),
        .flag(serial_tx_flag)
    );

    // Read views hold only present bits
    always_comb begin
        sys_view = '0;
        sys_view[sfb_pkg::BIT_WDOG] = watchdog_event_flag;
        sys_view[sfb_pkg::BIT_OSC] = osc_fault_flag;
        sys_view[sfb_pkg::BIT_NMI] = pin_nmi_flag;
        ser_view = '0;
        ser_view[sfb_pkg::BIT_RX] = serial_rx_flag;
        ser_view[sfb_pkg::BIT_TX] = serial_tx_flag;
    end

    // Status bits from high to low: tx, rx, nmi, osc, watchdog
    assign evt_pulse = {events.serial_tx, events.serial_rx,
        events.pin_nmi, events.osc_fault,
        wdog_set};

    // Enables and event status; event set wins over write-one clear
    always_comb begin
        next_serial_enables = serial_enables;
        next_int_enable = int_enable;
        next_evt_mask = evt_mask;
        if (wr_en_reg) begin
            next_serial_enables = wdata & sfb_pkg::SER_MASK;
        end
        if (wr_ie) begin
            next_int_enable = wdata & sfb_pkg::IE_MASK;
        end
        if (wr_mask) begin
            next_evt_mask = wdata[sfb_pkg::NUM_EVT-1:0];
        end
        next_evt_status = evt_status;
        if (wr_stat) begin
            next_evt_status = evt_status & ~wdata[sfb_pkg::NUM_EVT-1:0];
        end
        next_evt_status = next_evt_status | evt_pulse;
        if (power_up_clear) begin
            next_serial_enables = sfb_pkg::PUC_VALUE;
            next_int_enable = sfb_pkg::PUC_VALUE;
            next_evt_status = '0;
            next_evt_mask = '0;
        end
    end

    // Requests, enables out and interrupt line
    always_comb begin
        next_requests.watchdog_int = watchdog_event_flag && !watchdog_mode
            && int_enable[sfb_pkg::BIT_IE_WDOG];
        next_requests.osc_int = osc_fault_flag
            && int_enable[sfb_pkg::BIT_IE_OSC];
        next_requests.nmi_int = pin_nmi_flag
            && int_enable[sfb_pkg::BIT_IE_NMI];
        next_requests.rx_int = serial_rx_flag
            && int_enable[sfb_pkg::BIT_IE_RX];
        next_requests.tx_int = serial_tx_flag
            && int_enable[sfb_pkg::BIT_IE_TX];
        // Sync mode hands bit 0 to the shared enable
        next_rx_en = serial_enables[sfb_pkg::BIT_RX] && !sync_mode;
        next_tx_en = serial_enables[sfb_pkg::BIT_TX] && !sync_mode;
        next_sync_en = serial_enables[sfb_pkg::BIT_RX] && sync_mode;
        next_irq = |(evt_status & evt_mask);
    end

    // Read mux; misaligned or unknown addresses are unmapped
    always_comb begin
        mapped = aligned;
        rdata_mux = sfb_pkg::ZERO_WORD;
        case (reg_index)
            sfb_pkg::ADDR_SYS_FLAGS: rdata_mux[RW-1:0] = sys_view;
            sfb_pkg::ADDR_SER_FLAGS: rdata_mux[RW-1:0] = ser_view;
            sfb_pkg::ADDR_ENABLES_ONE: rdata_mux[RW-1:0] = '0;
            sfb_pkg::ADDR_SER_ENABLES: rdata_mux[RW-1:0] = serial_enables;
            sfb_pkg::ADDR_INT_ENABLE: rdata_mux[RW-1:0] = int_enable;
            sfb_pkg::ADDR_EVT_STATUS: begin
                rdata_mux[sfb_pkg::NUM_EVT-1:0] = evt_status;
            end
            sfb_pkg::ADDR_EVT_MASK: begin
                rdata_mux[sfb_pkg::NUM_EVT-1:0] = evt_mask;
            end
            default: mapped = 1'b0;
        endcase
    end

    // APB answer, one wait-free access phase
    always_comb begin
        next_state = sfb_pkg::SFB_IDLE;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        case (state)
            sfb_pkg::SFB_IDLE: begin
                if (psel && !penable) begin
                    next_state = sfb_pkg::SFB_ACCESS;
                    next_pready = 1'b1;
                    next_pslverr = !mapped;
                    next_prdata = (pwrite || !mapped)
                        ? sfb_pkg::ZERO_WORD : rdata_mux;
                end
            end
            sfb_pkg::SFB_ACCESS: next_state = sfb_pkg::SFB_IDLE;
            default: next_state = sfb_pkg::SFB_IDLE;
        endcase
    end

    // Enable, mask and event status registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_enables <= sfb_pkg::POR_VALUE;
            int_enable <= sfb_pkg::POR_VALUE;
            evt_status <= '0;
            evt_mask <= '0;
        end else begin
            serial_enables <= next_serial_enables;
            int_enable <= next_int_enable;
            evt_status <= next_evt_status;
            evt_mask <= next_evt_mask;
        end
    end

    // Registered requests, enables and interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            requests <= '0;
            async_rx_enable <= 1'b0;
            async_tx_enable <= 1'b0;
            sync_serial_enable <= 1'b0;
            irq <= 1'b0;
        end else begin
            requests <= next_requests;
            async_rx_enable <= next_rx_en;
            async_tx_enable <= next_tx_en;
            sync_serial_enable <= next_sync_en;
            irq <= next_irq;
        end
    end

    // APB answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= sfb_pkg::ZERO_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
            state <= sfb_pkg::SFB_IDLE;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            state <= next_state;
        end
    end
endmodule // sfb_bank

// *** sfb_bank_props.sv ***
// Port-level checker for the flag and module enable register bank
module sfb_bank_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic power_up_clear,
    input wire logic pin_reset_mode_reset,
    input wire logic watchdog_mode,
    input wire logic sync_mode,
    input wire sfb_pkg::sfb_events_t events,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sfb_pkg::ADDR_W-1:0] paddr,
    input wire logic [sfb_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [sfb_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire sfb_pkg::sfb_requests_t requests,
    input wire logic async_rx_enable,
    input wire logic async_tx_enable,
    input wire logic sync_serial_enable,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_err; psel && !penable && paddr == 8'h1C |=> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_mis; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr;
    endproperty
    a_mis: assert property (p_mis) else $error("misaligned taken");
    property p_rd04; psel && !penable && !pwrite
        && paddr == sfb_pkg::ADDR_ENABLES_ONE * 4 |=> prdata == '0
        && !pslverr;
    endproperty
    a_rd04: assert property (p_rd04) else $error("bad read");
    property p_hi; pready && !pwrite && (paddr == sfb_pkg::ADDR_SER_FLAGS * 4
        || paddr == sfb_pkg::ADDR_SER_ENABLES * 4) |-> prdata[31:2] == '0;
    endproperty
    a_hi: assert property (p_hi) else $error("absent bits set");
    property p_sync; sync_mode |=> !async_rx_enable && !async_tx_enable;
    endproperty
    a_sync: assert property (p_sync) else $error("async on");
    property p_spi; $rose(sync_serial_enable) |-> $past(sync_mode);
    endproperty
    a_spi: assert property (p_spi) else $error("sync on");
    property p_wdm; watchdog_mode [*2] |-> !requests.watchdog_int;
    endproperty
    a_wdm: assert property (p_wdm) else $error("wdog request");
    property p_puc; power_up_clear && !psel |=> ##1
        (requests == '0 && !irq && !async_rx_enable); endproperty
    a_puc: assert property (p_puc) else $error("not cleared");
    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
    c_puc: cover property (power_up_clear);
endmodule // sfb_bank_props

bind sfb_bank sfb_bank_props sfb_bank_props_inst (.pclk, .presetn,
    .power_up_clear, .pin_reset_mode_reset, .watchdog_mode, .sync_mode,
    .events, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .requests, .async_rx_enable, .async_tx_enable,
    .sync_serial_enable, .irq);

// *** testbench.sv ***
// Self-checking bench for the flag and module enable register bank
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [7:0] a; logic [31:0] e; logic err;} sfb_row_t;
    logic pclk = 0, presetn = 0, power_up_clear = 0;
    logic pin_reset_mode_reset = 0, watchdog_mode = 0, sync_mode = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic [3:0] pstrb = 4'hF;
    logic async_rx_enable, async_tx_enable, sync_serial_enable;
    sfb_pkg::sfb_events_t events = 6'h00;
    sfb_pkg::sfb_requests_t requests;
    int n_checks = 0, n_mismatch = 0;
    sfb_row_t rows[7] = '{'{8'h03, 32'h0000_0003, 1'b0},
        '{8'h05, 32'h0000_0003, 1'b0}, '{8'h04, 32'h0000_0000, 1'b0},
        '{8'h02, 32'h0000_0013, 1'b0}, '{8'h08, 32'h0000_0073, 1'b0},
        '{8'h10, 32'h0000_001F, 1'b0}, '{8'h07, 32'h0000_0000, 1'b1}};
    always #5 pclk = ~pclk;
    sfb_bank sfb_bank_inst (.pclk, .presetn, .power_up_clear,
        .pin_reset_mode_reset, .watchdog_mode, .sync_mode, .events, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .requests, .async_rx_enable, .async_tx_enable,
        .sync_serial_enable, .irq);
    task automatic chk(input string s, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    // Starts right after a rising edge, ends right after one
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Register index to word-aligned byte address
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, {a[5:0], 2'b00}, 32'h0000_0000);
        chk("rdata", e, rdat);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, {a[5:0], 2'b00}, d);
    endtask
    task automatic pulse(input logic [5:0] e);
        events <= e;
        @(posedge pclk);
        events <= 6'h00;
        @(posedge pclk);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 2; i < 6; i++) rc(8'(i), 32'h0000_0000);
        foreach (rows[i]) begin
            wr(rows[i].a, 32'h0000_00FF);
            rc(rows[i].a, rows[i].e);
            chk("pslverr", 32'(rows[i].err), 32'(rerr));
        end
        @(negedge pclk);
        chk("requests", 32'h0000_001F, 32'(requests));
        chk("enables", 32'h0000_0006, 32'({async_rx_enable,
            async_tx_enable, sync_serial_enable}));
        @(posedge pclk);
        watchdog_mode <= 1'b1;
        sync_mode <= 1'b1;
        repeat (3) @(negedge pclk);
        chk("requests", 32'h0000_000F, 32'(requests));
        chk("enables", 32'h0000_0001, 32'({async_rx_enable,
            async_tx_enable, sync_serial_enable}));
        @(posedge pclk);
        watchdog_mode <= 1'b0;
        sync_mode <= 1'b0;
        power_up_clear <= 1'b1;
        @(posedge pclk);
        power_up_clear <= 1'b0;
        @(posedge pclk);
        rc(sfb_pkg::ADDR_SER_FLAGS, 32'h0000_0000);
        rc(sfb_pkg::ADDR_SER_ENABLES, 32'h0000_0000);
        rc(sfb_pkg::ADDR_SYS_FLAGS, 32'h0000_0001);
        pulse(6'h3F);
        rc(sfb_pkg::ADDR_SYS_FLAGS, 32'h0000_0013);
        rc(sfb_pkg::ADDR_SER_FLAGS, 32'h0000_0003);
        apb(1'b1, 8'h0D, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, 32'(rerr));
        rc(sfb_pkg::ADDR_SER_FLAGS, 32'h0000_0003);
        rc(sfb_pkg::ADDR_EVT_STATUS, 32'h0000_001F);
        wr(sfb_pkg::ADDR_EVT_MASK, 32'h0000_001F);
        @(negedge pclk);
        chk("irq", 32'h0000_0001, 32'(irq));
        @(posedge pclk);
        wr(sfb_pkg::ADDR_EVT_STATUS, 32'h0000_001F);
        rc(sfb_pkg::ADDR_EVT_STATUS, 32'h0000_0000);
        @(negedge pclk);
        chk("irq", 32'h0000_0000, 32'(irq));
        @(posedge pclk);
        pin_reset_mode_reset <= 1'b1;
        @(posedge pclk);
        pin_reset_mode_reset <= 1'b0;
        rc(sfb_pkg::ADDR_SYS_FLAGS, 32'h0000_0012);
        pulse(6'h20);
        rc(sfb_pkg::ADDR_SYS_FLAGS, 32'h0000_0012);
        watchdog_mode <= 1'b1;
        pulse(6'h20);
        rc(sfb_pkg::ADDR_SYS_FLAGS, 32'h0000_0013);
        watchdog_mode <= 1'b0;
        pin_reset_mode_reset <= 1'b1;
        @(posedge pclk);
        pin_reset_mode_reset <= 1'b0;
        pulse(6'h10);
        rc(sfb_pkg::ADDR_SYS_FLAGS, 32'h0000_0013);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(sfb_pkg::ADDR_SYS_FLAGS, 32'h0000_0000);
        wrap_up();
    end
endmodule // testbench
